// *** ccdce_alu.sv ***
// Combinational datapath for the clear, complement and decrement instructions.
// Assumes the caller presents the addressed file register value for the held command.
`timescale 1ns/10ps
`default_nettype none
module ccdce_alu
  import ccdce_pkg::*;
(
  input wire ccdce_cmd_t cmd_in,
  input wire logic [7:0] fdata_in,
  output ccdce_res_t res_out
);

  // Zero detect, used by the complement and decrement result paths
  function automatic logic is_zero(input logic [7:0] v);
    return (v == CCDCE_ZERO8);
  endfunction

  // Result, destination and flag decode
  always_comb begin
    res_out = '0;
    unique case (cmd_in.op)
      CCDCE_CLEAR_WORKING_OP: begin
        // W cleared, Z forced high
        res_out.to_w = 1'b1;
        res_out.set_z = 1'b1;
        res_out.zero = 1'b1;
      end
      CCDCE_CLEAR_FILE_REG_OP: begin
        // File cleared, Z forced high
        res_out.to_file = 1'b1;
        res_out.set_z = 1'b1;
        res_out.zero = 1'b1;
      end
      CCDCE_COMPLEMENT_OP: begin
        res_out.value = ~fdata_in;
        res_out.to_w = !cmd_in.dest;
        res_out.to_file = cmd_in.dest;
        res_out.set_z = 1'b1;
        res_out.zero = is_zero(~fdata_in);
      end
      CCDCE_DECREMENT_OP, CCDCE_DECREMENT_SKIP_ZERO_OP: begin
        // Wraps 00h to FFh, no borrow kept
        res_out.value = fdata_in - 8'h01;
        res_out.to_w = !cmd_in.dest;
        res_out.to_file = cmd_in.dest;
        res_out.zero = is_zero(fdata_in - 8'h01);
        res_out.set_z = (cmd_in.op == CCDCE_DECREMENT_OP);
        res_out.skip = (cmd_in.op == CCDCE_DECREMENT_SKIP_ZERO_OP) && is_zero(fdata_in - 8'h01);
      end
      default: begin
        // Call, watchdog clear and no-op use no datapath
        res_out = '0;
      end
    endcase
  end

endmodule // ccdce_alu
`default_nettype wire

// *** ccdce_apb_master.sv ***
// APB master model standing in for the processor side of the register bus.
// Assumes the slave answers on pready_in; the bench sequences the transfers.
`timescale 1ns/10ps
`default_nettype none
module ccdce_apb_master (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  // Idle bus from time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h00000000;
  end

  // One transfer; request stays up so another may follow at once
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= addr;
    pwdata_out <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    // Ready, data and error are taken at the same rising edge; slave outputs move only by NBA
    @(posedge clk_in);
    while (pready_in !== 1'b1) begin
      @(posedge clk_in);
    end
    // No own limit: only the bench watchdog ends a hung wait
    rd = prdata_in;
    err = pslverr_in;
  endtask

  // Drop the request; write data turns over so stale data never looks valid
  task automatic release_bus();
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out <= ~pwdata_out;
    @(posedge clk_in);
  endtask
endmodule // ccdce_apb_master
`default_nettype wire

// *** ccdce_core.sv ***
// Executor for clear, complement, decrement, skip, call and watchdog-clear instructions.
// Assumes an APB3 master on clk_in; commands arrive as writes to the command register.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ccdce_core
  import ccdce_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  ccdce_state_t state; // Sequencer
  ccdce_cmd_t cmd; // Held instruction
  ccdce_res_t res; // Datapath answer
  logic [7:0] wreg; // Working register
  logic [7:0] status; // Flags and page bits
  logic [10:0] pc; // Program counter
  logic [10:0] stack0; // Top of stack
  logic [10:0] stack1; // Second level
  logic [7:0] watchdog_counter; // Watchdog count
  logic [7:0] prescaler; // Shared prescaler
  logic psa; // High: prescaler on watchdog
  logic skip_seen; // Last instruction skipped
  logic [7:0] file_mem [CCDCE_FILE_DEPTH]; // Data registers
  logic [7:0] fdata; // Addressed data register
  logic exec; // Instruction executes now
  logic busy; // Sequencer not idle
  logic access; // Commit edge of a transfer
  logic wr_ok; // Accepted write commits
  logic cmd_go; // Command write commits
  logic [7:0] next_rdata; // Read mux
  logic next_err; // Error answer
  logic file_hit; // Address in file window

  assign exec = (state == CCDCE_EXEC);
  assign busy = (state != CCDCE_IDLE);
  assign fdata = file_mem[cmd.faddr];
  // Request is held until the edge with pready high
  assign access = psel_in && penable_in && pready_out;
  assign wr_ok = access && pwrite_in && !pslverr_out;
  assign cmd_go = wr_ok && (paddr_in == CCDCE_CMD_OFS);
  assign file_hit = (paddr_in[7] == 1'b1) && (paddr_in[1:0] == 2'b00);

  // Datapath for results and zero flag
  ccdce_alu u_alu (
    .cmd_in(cmd),
    .fdata_in(fdata),
    .res_out(res)
  );

  // Word decode for a fixed register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return (a == ofs);
  endfunction

  // Read mux and error decode
  always_comb begin
    next_rdata = CCDCE_ZERO8;
    next_err = 1'b0;
    if (file_hit) begin
      next_rdata = file_mem[paddr_in[6:2]];
    end else if (hit(paddr_in, CCDCE_WREG_OFS)) begin
      next_rdata = wreg;
    end else if (hit(paddr_in, CCDCE_STATUS_OFS)) begin
      next_rdata = status;
    end else if (!(hit(paddr_in, CCDCE_CMD_OFS) || hit(paddr_in, CCDCE_PC_OFS) ||
                   hit(paddr_in, CCDCE_STACK_OFS) || hit(paddr_in, CCDCE_WATCHDOG_OFS) ||
                   hit(paddr_in, CCDCE_CORE_OFS))) begin
      // Unmapped word or unaligned address
      next_err = 1'b1;
    end
    // Writes while an instruction runs would race it
    if (pwrite_in && busy) begin
      next_err = 1'b1;
    end
  end

  // APB answer: one wait state, all outputs registered
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
    end else if (psel_in && penable_in && !pready_out) begin
      pready_out <= 1'b1;
      pslverr_out <= next_err;
      // Wide registers bypass the byte mux
      if (hit(paddr_in, CCDCE_CMD_OFS)) begin
        prdata_out <= {15'h0000, cmd};
      end else if (hit(paddr_in, CCDCE_PC_OFS)) begin
        prdata_out <= {21'h000000, pc};
      end else if (hit(paddr_in, CCDCE_STACK_OFS)) begin
        prdata_out <= {10'h000, stack1, stack0};
      end else if (hit(paddr_in, CCDCE_WATCHDOG_OFS)) begin
        prdata_out <= {15'h0000, psa, prescaler, watchdog_counter};
      end else if (hit(paddr_in, CCDCE_CORE_OFS)) begin
        prdata_out <= {28'h0000000, state, skip_seen, busy};
      end else begin
        prdata_out <= {24'h000000, next_rdata};
      end
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // Command capture, only when idle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd <= '0;
    end else if (cmd_go) begin
      cmd <= ccdce_cmd_t'(pwdata_in[CCDCE_CMD_W-1:0]);
    end
  end

  // Sequencer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= CCDCE_IDLE;
    end else begin
      unique case (state)
        CCDCE_IDLE: begin
          if (cmd_go) begin
            state <= CCDCE_EXEC;
          end
        end
        CCDCE_EXEC: begin
          if (cmd.op == CCDCE_CALL_OP || res.skip) begin
            state <= CCDCE_SECOND;
          end else begin
            state <= CCDCE_IDLE;
          end
        end
        CCDCE_SECOND: begin
          state <= CCDCE_IDLE;
        end
        default: begin
          // Unused code 2'b11 recovers to idle
          state <= CCDCE_IDLE;
        end
      endcase
    end
  end

  // Skip indicator, cleared by the next command
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      skip_seen <= 1'b0;
    end else if (exec) begin
      skip_seen <= res.skip;
    end
  end

  // Working register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wreg <= CCDCE_ZERO8;
    end else if (exec && res.to_w) begin
      wreg <= res.value;
    end else if (wr_ok && hit(paddr_in, CCDCE_WREG_OFS)) begin
      wreg <= pwdata_in[7:0];
    end
  end

  // Status flags
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status <= CCDCE_STATUS_RST;
    end else if (exec) begin
      if (res.set_z) begin
        status[CCDCE_Z_BIT] <= res.zero;
      end
      if (cmd.op == CCDCE_WATCHDOG_CLEAR_OP) begin
        status[CCDCE_TIMEOUT_N_BIT] <= 1'b1;
        status[CCDCE_POWERDOWN_N_BIT] <= 1'b1;
      end
    end else if (wr_ok && hit(paddr_in, CCDCE_STATUS_OFS)) begin
      status <= pwdata_in[7:0];
    end
  end

  // Program counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc <= CCDCE_PC_RST;
    end else if (exec) begin
      if (cmd.op == CCDCE_CALL_OP) begin
        pc <= {status[CCDCE_PAGE_HI:CCDCE_PAGE_LO], 1'b0, cmd.literal};
      end else begin
        pc <= pc + CCDCE_PC_ONE;
      end
    end else if (state == CCDCE_SECOND && cmd.op != CCDCE_CALL_OP) begin
      pc <= pc + CCDCE_PC_ONE;
    end else if (wr_ok && hit(paddr_in, CCDCE_PC_OFS)) begin
      pc <= pwdata_in[10:0];
    end
  end

  // Two-level return stack
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stack0 <= CCDCE_PC_RST;
      stack1 <= CCDCE_PC_RST;
    end else if (exec && cmd.op == CCDCE_CALL_OP) begin
      stack0 <= pc + CCDCE_PC_ONE;
      stack1 <= stack0;
    end
  end

  // Watchdog counter, prescaler and its assignment
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      watchdog_counter <= CCDCE_ZERO8;
      prescaler <= CCDCE_ZERO8;
      psa <= CCDCE_PSA_RST;
    end else if (exec && cmd.op == CCDCE_WATCHDOG_CLEAR_OP) begin
      watchdog_counter <= CCDCE_ZERO8;
      if (psa) begin
        prescaler <= CCDCE_ZERO8;
      end
    end else if (wr_ok && hit(paddr_in, CCDCE_WATCHDOG_OFS)) begin
      // Counting itself lives outside this block
      watchdog_counter <= pwdata_in[7:0];
      prescaler <= pwdata_in[CCDCE_PRE_LO +: 8];
      psa <= pwdata_in[CCDCE_PSA_BIT];
    end
  end

  // Data register file
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < CCDCE_FILE_DEPTH; i++) begin
        file_mem[i] <= CCDCE_ZERO8;
      end
    end else if (exec && res.to_file) begin
      file_mem[cmd.faddr] <= res.value;
    end else if (wr_ok && file_hit) begin
      file_mem[paddr_in[6:2]] <= pwdata_in[7:0];
    end
  end

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_clear_w_zero: assert property (
    exec && cmd.op == CCDCE_CLEAR_WORKING_OP |=> wreg == 8'h00 && status[CCDCE_Z_BIT])
    else $error("clear W did not zero W and set Z");

  chk_call_push: assert property (
    exec && cmd.op == CCDCE_CALL_OP |=> stack0 == $past(pc) + 11'h001 && stack1 == $past(stack0))
    else $error("call pushed wrong return address");

  chk_call_target: assert property (
    exec && cmd.op == CCDCE_CALL_OP |=>
      pc == {$past(status[6:5]), 1'b0, $past(cmd.literal)})
    else $error("call loaded wrong program counter");

  chk_call_two_cycles: assert property (
    exec && cmd.op == CCDCE_CALL_OP |=>
      state == CCDCE_SECOND && status == $past(status) ##1 state == CCDCE_IDLE)
    else $error("call length or flags wrong");

  chk_watchdog_zero: assert property (
    exec && cmd.op == CCDCE_WATCHDOG_CLEAR_OP |=> watchdog_counter == 8'h00)
    else $error("watchdog counter not cleared");

  chk_presc_owner: assert property (
    exec && cmd.op == CCDCE_WATCHDOG_CLEAR_OP |=>
      prescaler == ($past(psa) ? 8'h00 : $past(prescaler)))
    else $error("prescaler clear ignored assignment");

  chk_watchdog_flags: assert property (
    exec && cmd.op == CCDCE_WATCHDOG_CLEAR_OP |=>
      status[CCDCE_TIMEOUT_N_BIT] && status[CCDCE_POWERDOWN_N_BIT])
    else $error("timeout or powerdown flag not set");

  chk_clear_file_zero: assert property (
    exec && cmd.op == CCDCE_CLEAR_FILE_REG_OP |=>
      file_mem[$past(cmd.faddr)] == 8'h00 && status[CCDCE_Z_BIT])
    else $error("clear file did not zero register or set Z");

  chk_complement_dest: assert property (
    exec && cmd.op == CCDCE_COMPLEMENT_OP |=>
      ($past(cmd.dest) ? file_mem[$past(cmd.faddr)] : wreg) == ~$past(fdata))
    else $error("complement wrong value or target");

  chk_decrement_dest: assert property (
    exec && cmd.op == CCDCE_DECREMENT_OP |=>
      ($past(cmd.dest) ? file_mem[$past(cmd.faddr)] : wreg) == $past(fdata) - 8'h01)
    else $error("decrement wrong value or target");

  chk_dec_skip_flags: assert property (
    exec && cmd.op == CCDCE_DECREMENT_SKIP_ZERO_OP |=> status == $past(status) &&
      ($past(cmd.dest) ? file_mem[$past(cmd.faddr)] : wreg) == $past(fdata) - 8'h01)
    else $error("decrement-skip changed flags or wrote wrong value");

  chk_skip_noop: assert property (
    exec && cmd.op == CCDCE_DECREMENT_SKIP_ZERO_OP && fdata == 8'h01 |=>
      state == CCDCE_SECOND ##1 state == CCDCE_IDLE && pc == $past(pc, 2) + 11'h002)
    else $error("zero result did not skip");

  chk_zero_flag: assert property (
    exec && (cmd.op == CCDCE_COMPLEMENT_OP || cmd.op == CCDCE_DECREMENT_OP) |=>
      status[CCDCE_Z_BIT] == ($past(res.value) == 8'h00))
    else $error("zero flag does not follow result");

  chk_single_cycle: assert property (
    exec && cmd.op != CCDCE_CALL_OP && !(cmd.op == CCDCE_DECREMENT_SKIP_ZERO_OP && fdata == 8'h01)
      |=> state == CCDCE_IDLE)
    else $error("single-cycle instruction took longer");

endmodule // ccdce_core
`default_nettype wire

// *** ccdce_pkg.sv ***
// Constants, register map and carrier types for the clear/complement/decrement/call executor.
// Assumes an APB master with 32-bit data, byte addresses and one register per aligned word.
`default_nettype none
package ccdce_pkg;
  // Register byte offsets
  localparam logic [7:0] CCDCE_CMD_OFS = 8'h00;
  localparam logic [7:0] CCDCE_WREG_OFS = 8'h04;
  localparam logic [7:0] CCDCE_STATUS_OFS = 8'h08;
  localparam logic [7:0] CCDCE_PC_OFS = 8'h0C;
  localparam logic [7:0] CCDCE_STACK_OFS = 8'h10;
  localparam logic [7:0] CCDCE_WATCHDOG_OFS = 8'h14;
  localparam logic [7:0] CCDCE_CORE_OFS = 8'h18;
  // File registers 0..31 sit at 0x80 + 4*f
  localparam logic [7:0] CCDCE_FILE_BASE = 8'h80;
  localparam int CCDCE_FILE_DEPTH = 32;
  // Status bit positions
  localparam int CCDCE_Z_BIT = 2;
  localparam int CCDCE_POWERDOWN_N_BIT = 3;
  localparam int CCDCE_TIMEOUT_N_BIT = 4;
  localparam int CCDCE_PAGE_LO = 5;
  localparam int CCDCE_PAGE_HI = 6;
  // Watchdog register: counter 7:0, prescaler 15:8, assignment 16
  localparam int CCDCE_PRE_LO = 8;
  localparam int CCDCE_PSA_BIT = 16;
  // Command word width
  localparam int CCDCE_CMD_W = 17;
  // Reset values and the program counter step
  localparam logic [7:0] CCDCE_STATUS_RST = 8'h18;
  localparam logic [10:0] CCDCE_PC_RST = 11'h000;
  localparam logic [7:0] CCDCE_ZERO8 = 8'h00;
  localparam logic [10:0] CCDCE_PC_ONE = 11'h001;
  localparam logic CCDCE_PSA_RST = 1'b1;

  // Instruction group handled here
  typedef enum logic [2:0] {
    CCDCE_NO_OPERATION = 3'b000,
    CCDCE_CLEAR_WORKING_OP = 3'b001,
    CCDCE_CALL_OP = 3'b010,
    CCDCE_WATCHDOG_CLEAR_OP = 3'b011,
    CCDCE_CLEAR_FILE_REG_OP = 3'b100,
    CCDCE_COMPLEMENT_OP = 3'b101,
    CCDCE_DECREMENT_OP = 3'b110,
    CCDCE_DECREMENT_SKIP_ZERO_OP = 3'b111
  } ccdce_op_t;

  // Decoded instruction, low bits of the command word
  typedef struct packed {
    logic [7:0] literal;
    logic [4:0] faddr;
    logic dest;
    ccdce_op_t op;
  } ccdce_cmd_t;

  // Datapath answer for one instruction
  typedef struct packed {
    logic [7:0] value;
    logic zero;
    logic to_w;
    logic to_file;
    logic set_z;
    logic skip;
  } ccdce_res_t;

  // Sequencer states
  typedef enum logic [1:0] {
    CCDCE_IDLE = 2'b00,
    CCDCE_EXEC = 2'b01,
    CCDCE_SECOND = 2'b10
  } ccdce_state_t;
endpackage
`default_nettype wire

// *** clear_complement_decrement_call_exec_test.sv ***
// Self-checking bench for the instruction executor, driven over its register bus.
// Assumes the package and the APB master model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module clear_complement_decrement_call_exec_test;
  import ccdce_pkg::*;
  // One data instruction case and its expected outcome
  typedef struct packed {
    ccdce_op_t op;
    logic d;
    logic [4:0] f;
    logic [7:0] fin, w, fexp, st_pre, st_exp;
    logic [10:0] pc_inc;
  } ccdce_row_t;

  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, last_rd;
  ccdce_row_t rows [8];
  int num_errors = 0;
  int num_checks = 0;

  ccdce_core uut (.clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));
  ccdce_apb_master m (.clk_in(clk), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single transfer with an idle cycle after it
  task automatic rw(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    m.xfer(wr, addr, wd, last_rd, last_err);
    m.release_bus();
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    rw(1'b0, addr, 32'h00000000);
    chk(last_rd, exp);
  endtask

  // Byte address of a file register
  function automatic logic [7:0] fa(input logic [4:0] f);
    return CCDCE_FILE_BASE + {1'b0, f, 2'b00};
  endfunction

  // Issue a command, then poll busy under a bound
  task automatic exec(input ccdce_op_t op, input logic d, input logic [4:0] f, input logic [7:0] k);
    ccdce_cmd_t c;
    int n;
    c = '{literal: k, faddr: f, dest: d, op: op};
    rw(1'b1, CCDCE_CMD_OFS, {15'h0000, c});
    chk({31'h0, last_err}, 32'h0);
    n = 0;
    rw(1'b0, CCDCE_CORE_OFS, 32'h0);
    while (last_rd[0] !== 1'b0 && n < 10) begin
      rw(1'b0, CCDCE_CORE_OFS, 32'h0);
      n++;
    end
    chk({31'h0, last_rd[0]}, 32'h0);
  endtask

  task automatic final_report();
    $display("Checks: %0d, errors: %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #(20 * 5000);
    num_errors++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    final_report();
  end

  initial begin
    // Status before is the opposite of what the instruction should leave; decrement-skip rows expect it unchanged
    rows[0] = '{CCDCE_CLEAR_WORKING_OP, 1'b0, 5'h00, 8'h44, 8'h00, 8'h44, 8'h18, 8'h1C, 11'h001};
    rows[1] = '{CCDCE_CLEAR_FILE_REG_OP, 1'b0, 5'h1F, 8'h77, 8'h33, 8'h00, 8'h18, 8'h1C, 11'h001};
    rows[2] = '{CCDCE_COMPLEMENT_OP, 1'b0, 5'h05, 8'hFF, 8'h00, 8'hFF, 8'h18, 8'h1C, 11'h001};
    rows[3] = '{CCDCE_COMPLEMENT_OP, 1'b1, 5'h06, 8'h0F, 8'h33, 8'hF0, 8'h1C, 8'h18, 11'h001};
    rows[4] = '{CCDCE_DECREMENT_OP, 1'b1, 5'h07, 8'h00, 8'h33, 8'hFF, 8'h1C, 8'h18, 11'h001};
    rows[5] = '{CCDCE_DECREMENT_OP, 1'b0, 5'h08, 8'h01, 8'h00, 8'h01, 8'h18, 8'h1C, 11'h001};
    rows[6] = '{CCDCE_DECREMENT_SKIP_ZERO_OP, 1'b1, 5'h09, 8'h02, 8'h33, 8'h01, 8'h1C, 8'h1C, 11'h001};
    rows[7] = '{CCDCE_DECREMENT_SKIP_ZERO_OP, 1'b0, 5'h0A, 8'h01, 8'h00, 8'h01, 8'h18, 8'h18, 11'h002};
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(CCDCE_STATUS_OFS, 32'h18);
    rd_chk(CCDCE_WATCHDOG_OFS, 32'h10000);
    // Data instructions: result, destination, flags, program counter, skip flag
    foreach (rows[i]) begin
      rw(1'b1, CCDCE_WREG_OFS, 32'h33);
      rw(1'b1, fa(rows[i].f), {24'h0, rows[i].fin});
      rw(1'b1, CCDCE_STATUS_OFS, {24'h0, rows[i].st_pre});
      rw(1'b1, CCDCE_PC_OFS, 32'h100);
      exec(rows[i].op, rows[i].d, rows[i].f, 8'h00);
      rd_chk(CCDCE_WREG_OFS, {24'h0, rows[i].w});
      rd_chk(fa(rows[i].f), {24'h0, rows[i].fexp});
      rd_chk(CCDCE_STATUS_OFS, {24'h0, rows[i].st_exp});
      rd_chk(CCDCE_PC_OFS, 32'h100 + rows[i].pc_inc);
      rd_chk(CCDCE_CORE_OFS, (rows[i].pc_inc == 11'h002) ? 32'h2 : 32'h0);
    end
    // Call with upper page bit 6 set and PC bit 8 high, then a nested call
    rw(1'b1, CCDCE_STATUS_OFS, 32'h58);
    rw(1'b1, CCDCE_PC_OFS, 32'h1F3);
    exec(CCDCE_CALL_OP, 1'b0, 5'h00, 8'hAB);
    rd_chk(CCDCE_PC_OFS, 32'h4AB);
    rd_chk(CCDCE_STACK_OFS, 32'h1F4);
    rd_chk(CCDCE_STATUS_OFS, 32'h58);
    rw(1'b1, CCDCE_STATUS_OFS, 32'h1C);
    exec(CCDCE_CALL_OP, 1'b0, 5'h00, 8'h00);
    rd_chk(CCDCE_PC_OFS, 32'h000);
    rd_chk(CCDCE_STACK_OFS, 32'hFA4AC);
    rd_chk(CCDCE_STATUS_OFS, 32'h1C);
    // Watchdog clear with the prescaler assigned, then with it on the timer
    rw(1'b1, CCDCE_STATUS_OFS, 32'h00);
    rw(1'b1, CCDCE_WATCHDOG_OFS, 32'h1ABCD);
    exec(CCDCE_WATCHDOG_CLEAR_OP, 1'b0, 5'h00, 8'h00);
    rd_chk(CCDCE_WATCHDOG_OFS, 32'h10000);
    rd_chk(CCDCE_STATUS_OFS, 32'h18);
    rw(1'b1, CCDCE_WATCHDOG_OFS, 32'h0ABCD);
    exec(CCDCE_WATCHDOG_CLEAR_OP, 1'b0, 5'h00, 8'h00);
    rd_chk(CCDCE_WATCHDOG_OFS, 32'h0AB00);
    // Unmapped address is refused with zero data
    rw(1'b0, 8'h40, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    chk(last_rd, 32'h0);
    // Write right behind a call lands in its second cycle and is refused
    rw(1'b1, CCDCE_WREG_OFS, 32'h5A);
    m.xfer(1'b1, CCDCE_CMD_OFS, 32'h2, last_rd, last_err);
    chk({31'h0, last_err}, 32'h0);
    m.xfer(1'b1, CCDCE_WREG_OFS, 32'h99, last_rd, last_err);
    m.release_bus();
    chk({31'h0, last_err}, 32'h1);
    rd_chk(CCDCE_WREG_OFS, 32'h5A);
    final_report();
  end
endmodule // clear_complement_decrement_call_exec_test
`default_nettype wire
